/* plc_pkg.sv */
package plc_pkg;

  // ******************************************************************
  // Sizes and counts
  // ******************************************************************
  localparam int DW         = 8;
  localparam int PLD_NUM    = 2;
  localparam int PLD_IN     = 12;
  localparam int PLD_PT     = 8;
  localparam int PLD_OUT    = 4;
  localparam int CFG_WORDS  = 8;
  localparam int CFG_AW     = 3;
  localparam int QUEUE_NUM  = 2;
  localparam int QUEUE_DEPTH = 4;
  localparam int COND_OUTS  = 6;
  localparam int COND_NUM   = 16;
  localparam int BUF_DEPTH  = 2;

  // ******************************************************************
  // Working register indices on the system bus port
  // ******************************************************************
  localparam logic [2:0] REG_ACC0 = 3'h0;
  localparam logic [2:0] REG_ACC1 = 3'h1;
  localparam logic [2:0] REG_OPD0 = 3'h2;
  localparam logic [2:0] REG_OPD1 = 3'h3;
  localparam logic [2:0] REG_Q0   = 3'h4;
  localparam logic [2:0] REG_Q1   = 3'h5;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [7:0]  RST_DATA = 8'h00;
  localparam logic [15:0] RST_CFG  = 16'h0000;

  // ******************************************************************
  // Encodings and field layouts
  // ******************************************************************
  typedef enum logic [2:0] {
    ALU_INC, ALU_DEC, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS
  } plc_alu_op_t;

  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} plc_shift_t;

  // One dynamic configuration word, 16 bits
  typedef struct packed {
    logic        or_mask_en;
    logic        q1_act;
    logic        q0_act;
    logic        crc_mode;
    logic        tmux;
    logic        wr_acc;
    logic        dest_acc1;
    plc_shift_t  shift;
    logic [1:0]  srcb;
    logic [1:0]  srca;
    plc_alu_op_t op;
  } plc_cfg_word_t;

  // Static datapath setup
  typedef struct packed {
    logic [2:0]              msb;
    logic [7:0]              or_mask;
    logic [7:0]              poly;
    logic [1:0][7:0]         cmp_mask;
    logic [1:0][1:0]         cmp_pair;
    logic                    chain_cmp;
    logic [1:0]              q_out_mode;
    logic [1:0]              q_cap_alu;
    logic [1:0]              q_to_acc;
    logic                    stream_en;
    logic [5:0][3:0]         cond_sel;
  } plc_static_t;

  typedef struct packed {
    logic [7:0][11:0] true_sel;
    logic [7:0][11:0] comp_sel;
    logic [3:0][7:0]  or_sel;
    logic [3:0]       reg_out;
  } plc_pld_cfg_t;

  typedef struct packed {
    logic carry;
    logic shift;
    logic cmp_eq;
    logic cmp_lt;
  } plc_chain_t;

  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } plc_bus_req_t;

endpackage : plc_pkg

/* plc_cell.sv */
`timescale 1ns/100ps
// What this block does
// - Two independent sum-of-products logic arrays sit beside one datapath.
// - Array inputs come from routing; each output registered or combinational.
// - Each array takes twelve inputs, all reaching all eight product terms.
// - A product term ANDs any chosen inputs, true or inverted each.
// - Each output ORs a chosen set of the same eight terms.
// - One 8-bit operation plus compares and conditions per clock.
// - Six working registers reachable by firmware or DMA during operation.
// - Accumulators are sources, sinks and compare inputs; operand regs sources, compare inputs and queue-load sinks.
// - Two four-byte queues load registers or capture results; bus interface.
// - Configuration memory holds eight 16-bit words, each a full function.
// - Routing address picks the active configuration word every cycle.
// - Eight operations: inc, dec, add, sub, and, or, xor, pass.
// - One of shift left, shift right or nibble swap, plus an OR mask applied independently.
// - Two masked comparators over selectable register pairings.
// - Zero, all-ones, overflow conditions; selected conditions drive routing.
// - Conditions chain to neighbour cells over dedicated links.
// - Programmable most significant bit for arithmetic and shifts, with masking.
// - One CRC or sequence step per clock for a programmable polynomial.
// - Wider CRC or sequence uses array logic or chaining to neighbours.
// - Each queue is an input or output buffer; its status is selectable.
// - Carry and shift-out are registered for reuse in later cycles.
module plc_cell #(
  parameter int QDEPTH = plc_pkg::QUEUE_DEPTH
) (
  input  wire logic                                clk,        // Clock
  input  wire logic                                rst,        // Sync reset
  input  wire logic                                cfg_we,     // Config write
  input  wire logic [plc_pkg::CFG_AW-1:0]          cfg_waddr,  // Config index
  input  wire plc_pkg::plc_cfg_word_t              cfg_wdata,  // Config word
  input  wire logic [plc_pkg::CFG_AW-1:0]          cfg_addr,   // Routed select
  input  wire plc_pkg::plc_static_t                dp_setup,   // Static setup
  input  wire plc_pkg::plc_pld_cfg_t [1:0]         pld_cfg,    // Array setup
  input  wire logic [1:0][plc_pkg::PLD_IN-1:0]     pld_in,     // Array inputs
  output logic [1:0][plc_pkg::PLD_OUT-1:0]         pld_out,    // Array outputs
  input  wire plc_pkg::plc_chain_t                 chain_in,   // From lower cell
  output plc_pkg::plc_chain_t                      chain_out,  // To upper cell
  output logic [plc_pkg::COND_OUTS-1:0]            cond_out,   // To routing
  input  wire plc_pkg::plc_bus_req_t               bus_req,    // Bus request
  output logic [plc_pkg::DW-1:0]                   bus_rdata,  // Read data
  output logic                                     st_valid,   // Result valid
  output logic [plc_pkg::DW-1:0]                   st_data,    // Result word
  input  wire logic                                st_ready    // Taker ready
);

  localparam int CW = $clog2(QDEPTH + 1);
  localparam logic [CW-1:0] QFULL = CW'(QDEPTH);
  localparam logic [1:0] BFULL = 2'(plc_pkg::BUF_DEPTH);

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [7:0]                   a0;
    logic [7:0]                   a1;
    logic [7:0]                   d0;
    logic [7:0]                   d1;
    logic [1:0][QDEPTH-1:0][7:0]  q;
    logic [1:0][CW-1:0]           qcnt;
    logic [7:0][15:0]             ram;
    logic                         carry;
    logic                         sout;
    logic [1:0][7:0]              bdat;
    logic [1:0]                   bcnt;
    logic                         bvalid;
    logic [1:0][3:0]              pld_reg;
    plc_pkg::plc_chain_t          chain;
    logic [5:0]                   cond;
    logic [7:0]                   rdata;
  } plc_state_t;

  plc_state_t s_ff;
  plc_state_t nxt_s;

  // ******************************************************************
  // Decode helpers
  // ******************************************************************
  function automatic logic [7:0] plc_pick(input logic [1:0] code,
                                          input plc_state_t st);
    case (code)
      2'h0:    plc_pick = st.a0;
      2'h1:    plc_pick = st.a1;
      2'h2:    plc_pick = st.d0;
      default: plc_pick = st.d1;
    endcase
  endfunction : plc_pick

  // Compare pairings: a0/d0, a1/d1, a0/a1, a0/d1
  function automatic logic [15:0] plc_pair(input logic [1:0] code,
                                           input plc_state_t st);
    case (code)
      2'h0:    plc_pair = {st.a0, st.d0};
      2'h1:    plc_pair = {st.a1, st.d1};
      2'h2:    plc_pair = {st.a0, st.a1};
      default: plc_pair = {st.a0, st.d1};
    endcase
  endfunction : plc_pair

  // ******************************************************************
  // Logic arrays
  // ******************************************************************
  logic [1:0][7:0] pt;
  logic [1:0][3:0] sop;

  for (genvar g = 0; g < plc_pkg::PLD_NUM; g++)
  begin : g_pld
    for (genvar p = 0; p < plc_pkg::PLD_PT; p++)
    begin : g_pt
      // A term with no input selected stays true; tools leave it unused
      assign pt[g][p] = &(pld_in[g] | ~pld_cfg[g].true_sel[p]) &
                        &(~pld_in[g] | ~pld_cfg[g].comp_sel[p]);
    end
    for (genvar o = 0; o < plc_pkg::PLD_OUT; o++)
    begin : g_out
      assign sop[g][o] = |(pt[g] & pld_cfg[g].or_sel[o]);
      // Combinational mode bypasses the flop on purpose
      assign pld_out[g][o] = pld_cfg[g].reg_out[o] ? s_ff.pld_reg[g][o]
                                                   : sop[g][o];
    end
  end

  // ******************************************************************
  // Datapath
  // ******************************************************************
  plc_pkg::plc_cfg_word_t cw;
  logic [7:0]      srca, srcb, am, bm, bx, wm, r, sh, res;
  logic [8:0]      sum;
  logic [3:0]      cidx;
  logic            cin, sin, carry_n, sout_n, ovf, fb, zero, ones;
  logic [1:0]      eq, lt, q_empty, q_full, push, pop;
  logic [1:0][7:0] pdata;
  logic [15:0]     xy, condv;
  logic            want_push, stall, go, bpop;

  always_comb
  begin
    nxt_s = s_ff;
    cw = plc_pkg::plc_cfg_word_t'(s_ff.ram[cfg_addr]);
    wm = 8'((9'h002 << dp_setup.msb) - 9'h001);
    cin = cw.tmux ? s_ff.carry : chain_in.carry;
    sin = cw.tmux ? s_ff.sout : chain_in.shift;
    srca = plc_pick(cw.srca, s_ff);
    srcb = plc_pick(cw.srcb ^ 2'h2, s_ff);
    am = srca & wm;
    bm = srcb & wm;
    bx = 8'h00;
    case (cw.op)
      plc_pkg::ALU_INC:
      begin
        sum = {1'b0, am} + 9'h001;
        bx = 8'h01;
      end
      plc_pkg::ALU_DEC:
      begin
        sum = {1'b0, am} - 9'h001;
        bx = 8'hFE;
      end
      plc_pkg::ALU_ADD:
      begin
        sum = {1'b0, am} + {1'b0, bm} + {8'h00, cin};
        bx = bm;
      end
      plc_pkg::ALU_SUB:
      begin
        sum = {1'b0, am} - {1'b0, bm} - {8'h00, cin};
        bx = ~bm;
      end
      plc_pkg::ALU_AND: sum = {1'b0, am & bm};
      plc_pkg::ALU_OR:  sum = {1'b0, am | bm};
      plc_pkg::ALU_XOR: sum = {1'b0, am ^ bm};
      default:          sum = {1'b0, am};
    endcase
    cidx = {1'b0, dp_setup.msb} + 4'h1;
    carry_n = sum[cidx];
    r = sum[7:0];
    ovf = (cw.op inside {plc_pkg::ALU_INC, plc_pkg::ALU_DEC,
                         plc_pkg::ALU_ADD, plc_pkg::ALU_SUB}) &&
          (am[dp_setup.msb] == bx[dp_setup.msb]) &&
          (r[dp_setup.msb] != am[dp_setup.msb]);
    sout_n = 1'b0;
    fb = 1'b0;
    case (cw.shift)
      plc_pkg::SH_LEFT:
      begin
        sh = {r[6:0], sin};
        sout_n = r[dp_setup.msb];
      end
      plc_pkg::SH_RIGHT:
      begin
        sh = (r >> 1) | ({7'h00, sin} << dp_setup.msb);
        sout_n = r[0];
      end
      plc_pkg::SH_SWAP: sh = {r[3:0], r[7:4]};
      default:          sh = r;
    endcase
    if (cw.crc_mode)
    begin
      // Feedback enters from the neighbour so wider codes chain
      fb = am[dp_setup.msb] ^ sin;
      sh = {am[6:0], 1'b0} ^ (fb ? dp_setup.poly : 8'h00);
      sout_n = fb;
      carry_n = 1'b0;
    end
    if (cw.or_mask_en)
      sh = sh | dp_setup.or_mask;
    res = sh & wm;
    zero = (res == 8'h00);
    ones = (res == wm);

    for (int c = 0; c < 2; c++)
    begin
      xy = plc_pair(dp_setup.cmp_pair[c], s_ff);
      eq[c] = (xy[15:8] & dp_setup.cmp_mask[c]) ==
              (xy[7:0] & dp_setup.cmp_mask[c]);
      lt[c] = (xy[15:8] & dp_setup.cmp_mask[c]) <
              (xy[7:0] & dp_setup.cmp_mask[c]);
    end
    if (dp_setup.chain_cmp)
    begin
      lt[0] = lt[0] | (eq[0] & chain_in.cmp_lt);
      eq[0] = eq[0] & chain_in.cmp_eq;
    end

    for (int i = 0; i < 2; i++)
    begin
      q_empty[i] = (s_ff.qcnt[i] == '0);
      q_full[i] = (s_ff.qcnt[i] == QFULL);
    end

    // Result stream: the datapath waits rather than drop a word
    want_push = dp_setup.stream_en && cw.wr_acc;
    stall = want_push && (s_ff.bcnt == BFULL);
    go = !stall;
    bpop = s_ff.bvalid && st_ready;

    push = 2'b00;
    pop = 2'b00;
    pdata = '0;
    if (go)
    begin
      if (cw.wr_acc)
      begin
        if (cw.dest_acc1)
          nxt_s.a1 = res;
        else
          nxt_s.a0 = res;
      end
      nxt_s.carry = carry_n;
      nxt_s.sout = sout_n;
      for (int i = 0; i < 2; i++)
      begin
        if ((i == 0) ? cw.q0_act : cw.q1_act)
        begin
          if (dp_setup.q_out_mode[i])
          begin
            push[i] = !q_full[i];
            pdata[i] = dp_setup.q_cap_alu[i] ? res : plc_pick(2'(i), s_ff);
          end
          else if (!q_empty[i])
          begin
            pop[i] = 1'b1;
            if (dp_setup.q_to_acc[i] && i == 0)
              nxt_s.a0 = s_ff.q[i][0];
            else if (dp_setup.q_to_acc[i])
              nxt_s.a1 = s_ff.q[i][0];
            else if (i == 0)
              nxt_s.d0 = s_ff.q[i][0];
            else
              nxt_s.d1 = s_ff.q[i][0];
          end
        end
      end
    end

    // System bus: writes win over the datapath in the same cycle
    nxt_s.rdata = plc_pkg::RST_DATA;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        plc_pkg::REG_ACC0: nxt_s.a0 = bus_req.wdata;
        plc_pkg::REG_ACC1: nxt_s.a1 = bus_req.wdata;
        plc_pkg::REG_OPD0: nxt_s.d0 = bus_req.wdata;
        plc_pkg::REG_OPD1: nxt_s.d1 = bus_req.wdata;
        plc_pkg::REG_Q0, plc_pkg::REG_Q1:
        begin
          if (!dp_setup.q_out_mode[bus_req.addr[0]] &&
              !q_full[bus_req.addr[0]])
          begin
            push[bus_req.addr[0]] = 1'b1;
            pdata[bus_req.addr[0]] = bus_req.wdata;
          end
        end
        default: ;
      endcase
    end
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        plc_pkg::REG_ACC0: nxt_s.rdata = s_ff.a0;
        plc_pkg::REG_ACC1: nxt_s.rdata = s_ff.a1;
        plc_pkg::REG_OPD0: nxt_s.rdata = s_ff.d0;
        plc_pkg::REG_OPD1: nxt_s.rdata = s_ff.d1;
        plc_pkg::REG_Q0, plc_pkg::REG_Q1:
        begin
          if (dp_setup.q_out_mode[bus_req.addr[0]] &&
              !q_empty[bus_req.addr[0]])
          begin
            pop[bus_req.addr[0]] = 1'b1;
            nxt_s.rdata = s_ff.q[bus_req.addr[0]][0];
          end
        end
        default: ;
      endcase
    end

    // Queues keep the head at entry 0; a pop shifts the rest down
    for (int i = 0; i < 2; i++)
    begin
      if (pop[i])
      begin
        for (int k = 0; k < QDEPTH - 1; k++)
          nxt_s.q[i][k] = s_ff.q[i][k+1];
      end
      if (push[i])
        nxt_s.q[i][s_ff.qcnt[i] - CW'(pop[i])] = pdata[i];
      nxt_s.qcnt[i] = s_ff.qcnt[i] + CW'(push[i]) - CW'(pop[i]);
    end

    if (bpop)
      nxt_s.bdat[0] = s_ff.bdat[1];
    if (go && want_push)
      nxt_s.bdat[s_ff.bcnt - 2'(bpop)] = res;
    nxt_s.bcnt = s_ff.bcnt + 2'(go && want_push) - 2'(bpop);
    nxt_s.bvalid = (nxt_s.bcnt != 2'h0);

    if (cfg_we)
      nxt_s.ram[cfg_waddr] = cfg_wdata;

    nxt_s.pld_reg = sop;

    condv = {3'h0, q_full[1], q_empty[1], q_full[0], q_empty[0],
             sout_n, carry_n, ovf, ones, zero, lt[1], eq[1], lt[0], eq[0]};
    for (int k = 0; k < plc_pkg::COND_OUTS; k++)
      nxt_s.cond[k] = condv[dp_setup.cond_sel[k]];
    nxt_s.chain = '{carry: carry_n, shift: sout_n,
                    cmp_eq: eq[0], cmp_lt: lt[0]};
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign chain_out = s_ff.chain;
  assign cond_out = s_ff.cond;
  assign bus_rdata = s_ff.rdata;
  assign st_valid = s_ff.bvalid;
  assign st_data = s_ff.bdat[0];

endmodule : plc_cell

/* plc_cell_properties.sv */
`timescale 1ns/100ps
module plc_cell_properties #(
  parameter int QDEPTH = plc_pkg::QUEUE_DEPTH
) (
  input wire logic                        clk,       // Clock
  input wire logic                        rst,       // Sync reset
  input wire logic                        cfg_we,    // Config write
  input wire logic [2:0]                  cfg_waddr, // Config index
  input wire plc_pkg::plc_cfg_word_t      cfg_wdata, // Config word
  input wire logic [2:0]                  cfg_addr,  // Routed select
  input wire plc_pkg::plc_static_t        dp_setup,  // Static setup
  input wire plc_pkg::plc_pld_cfg_t [1:0] pld_cfg,   // Array setup
  input wire logic [1:0][11:0]            pld_in,    // Array inputs
  input wire logic [1:0][3:0]             pld_out,   // Array outputs
  input wire plc_pkg::plc_chain_t         chain_in,  // From lower cell
  input wire plc_pkg::plc_chain_t         chain_out, // To upper cell
  input wire logic [5:0]                  cond_out,  // To routing
  input wire plc_pkg::plc_bus_req_t       bus_req,   // Bus request
  input wire logic [7:0]                  bus_rdata, // Read data
  input wire logic                        st_valid,  // Result valid
  input wire logic [7:0]                  st_data,   // Result word
  input wire logic                        st_ready   // Taker ready
);
  // ******************************************************************
  // Reference sum of products, both arrays packed as pld_out
  // ******************************************************************
  function automatic logic [7:0] sop_f(input plc_pkg::plc_pld_cfg_t [1:0] c,
                                       input logic [1:0][11:0] x);
    logic [7:0] r;
    logic [7:0] pt;
    r = 8'h00;
    for (int a = 0; a < 2; a++)
    begin
      for (int t = 0; t < 8; t++)
        pt[t] = ~|((c[a].true_sel[t] & ~x[a]) | (c[a].comp_sel[t] & x[a]));
      for (int o = 0; o < 4; o++)
        r[a*4+o] = |(pt & c[a].or_sel[o]);
    end
    return r;
  endfunction : sop_f

  wire logic [7:0] sop_w = sop_f(pld_cfg, pld_in);
  wire logic [7:0] regm  = {pld_cfg[1].reg_out, pld_cfg[0].reg_out};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_held;
    st_valid && !st_ready;
  endsequence
  sequence s_kept;
    st_valid && $stable(st_data);
  endsequence

  a_stream_hold: assert property (s_held |=> s_kept)
    else $error("stream word changed while stalled");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data without a read");
  a_rdata_unmapped: assert property (bus_req.rd && bus_req.addr > 3'h5 |=> bus_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_reset_clear: assert property ($fell(rst) |-> !st_valid && chain_out == 4'h0)
    else $error("outputs not cleared by reset");
  a_pld_comb: assert property (((pld_out ^ sop_w) & ~regm) == 8'h00)
    else $error("combinational array output wrong");
  a_pld_reg: assert property (!$past(rst) |-> ((pld_out ^ $past(sop_w)) & regm) == 8'h00)
    else $error("registered array output wrong");
  a_cond_const: assert property ($past(dp_setup.cond_sel[5]) > 4'hC |-> !cond_out[5])
    else $error("spare condition code not zero");
  a_q_status: assert property (dp_setup.cond_sel[0] == 4'h9 && dp_setup.cond_sel[1] == 4'hA
    |-> !(cond_out[0] && cond_out[1]))
    else $error("queue empty and full together");
endmodule : plc_cell_properties

bind plc_cell plc_cell_properties #(.QDEPTH(QDEPTH)) chk_u (
  .clk(clk), .rst(rst), .cfg_we(cfg_we), .cfg_waddr(cfg_waddr),
  .cfg_wdata(cfg_wdata), .cfg_addr(cfg_addr), .dp_setup(dp_setup),
  .pld_cfg(pld_cfg), .pld_in(pld_in), .pld_out(pld_out),
  .chain_in(chain_in), .chain_out(chain_out), .cond_out(cond_out),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .st_valid(st_valid),
  .st_data(st_data), .st_ready(st_ready)
);

/* plc_host_model.sv */
`timescale 1ns/100ps
module plc_host_model (
  input  wire logic             clk,       // Clock
  input  wire logic [7:0]       bus_rdata, // Read data
  output plc_pkg::plc_bus_req_t bus_req    // Request
);
  initial bus_req = '{addr: 3'h7, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};

  // Released lines flip so a stale value is never mistaken for a good one
  task automatic idle();
    bus_req.wr    = 1'b0;
    bus_req.rd    = 1'b0;
    bus_req.addr  = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
  endtask : idle

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    idle();
  endtask : wr

  // Answer stands just after the taking edge, so sample it at the next falling edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~bus_req.wdata};
    @(negedge clk);
    d = bus_rdata;
    idle();
  endtask : rd
endmodule : plc_host_model

/* programmable_logic_datapath_cell_tb.sv */
`timescale 1ns/100ps
module programmable_logic_datapath_cell_tb;
  logic                        clk, rst, cfg_we, st_ready, st_valid;
  logic [2:0]                  cfg_waddr, cfg_addr;
  plc_pkg::plc_cfg_word_t      cfg_wdata, w;
  plc_pkg::plc_static_t        dp_setup;
  plc_pkg::plc_pld_cfg_t [1:0] pld_cfg;
  logic [1:0][11:0]            pld_in;
  logic [1:0][3:0]             pld_out;
  plc_pkg::plc_chain_t         chain_in, chain_out;
  logic [5:0]                  cond_out;
  plc_pkg::plc_bus_req_t       bus_req;
  logic [7:0]                  bus_rdata, st_data, a, b, v;
  logic [7:0]                  exp_q [$];
  int                          seed = 32'h54EC79F8;
  int                          n_fail = 0;
  int                          total_checks = 0;

  plc_cell dut_u (.clk(clk), .rst(rst), .cfg_we(cfg_we),
    .cfg_waddr(cfg_waddr), .cfg_wdata(cfg_wdata), .cfg_addr(cfg_addr),
    .dp_setup(dp_setup), .pld_cfg(pld_cfg), .pld_in(pld_in),
    .pld_out(pld_out), .chain_in(chain_in), .chain_out(chain_out),
    .cond_out(cond_out), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .st_valid(st_valid), .st_data(st_data), .st_ready(st_ready));
  plc_host_model host_u (.clk(clk), .bus_rdata(bus_rdata), .bus_req(bus_req));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    pld_in <= 24'($random(seed));
    chain_in.cmp_eq <= 1'($random(seed));
  end

  // ******************************************************************
  // Shared tasks and reference
  // ******************************************************************
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic rchk(input logic [2:0] ad, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(ad, d);
    chk8("bus_rdata", e, d);
  endtask : rchk

  // Word is written, then selected for n cycles, then idle word 0 again
  task automatic exec(input logic [2:0] i, input plc_pkg::plc_cfg_word_t cw,
                      input int n);
    @(negedge clk);
    cfg_we = 1'b1;
    cfg_waddr = i;
    cfg_wdata = cw;
    @(negedge clk);
    cfg_we = 1'b0;
    cfg_addr = i;
    repeat (n) @(negedge clk);
    cfg_addr = 3'h0;
  endtask : exec

  task automatic pld_rand();
    for (int k = 0; k < 2; k++)
    begin
      for (int t = 0; t < 8; t++)
      begin
        pld_cfg[k].true_sel[t] = 12'($random(seed) & $random(seed)) | 12'h001;
        pld_cfg[k].comp_sel[t] = 12'($random(seed) & $random(seed));
      end
      pld_cfg[k].or_sel = 32'($random(seed));
      pld_cfg[k].reg_out = 4'($random(seed));
    end
  endtask : pld_rand

  function automatic logic [7:0] ref_f(plc_pkg::plc_cfg_word_t cw,
                                       logic [7:0] x, logic [7:0] y);
    logic [7:0] r;
    case (cw.op)
      plc_pkg::ALU_INC: r = x + 8'h01;
      plc_pkg::ALU_DEC: r = x - 8'h01;
      plc_pkg::ALU_ADD: r = x + y;
      plc_pkg::ALU_SUB: r = x - y;
      plc_pkg::ALU_AND: r = x & y;
      plc_pkg::ALU_OR:  r = x | y;
      plc_pkg::ALU_XOR: r = x ^ y;
      default:          r = x;
    endcase
    case (cw.shift)
      plc_pkg::SH_LEFT:  r = {r[6:0], 1'b0};
      plc_pkg::SH_RIGHT: r = {1'b0, r[7:1]};
      plc_pkg::SH_SWAP:  r = {r[3:0], r[7:4]};
      default:           r = r;
    endcase
    if (cw.or_mask_en)
      r = r | dp_setup.or_mask;
    if (cw.crc_mode)
      r = {x[6:0], 1'b0} ^ (x[7] ? dp_setup.poly : 8'h00);
    return r;
  endfunction : ref_f

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    {rst, cfg_we, st_ready, cfg_waddr, cfg_addr} = 9'h100;
    cfg_wdata = '0;
    chain_in = '0;
    pld_in = '0;
    dp_setup = '0;
    dp_setup.msb = 3'h7;
    dp_setup.or_mask = 8'h30;
    dp_setup.poly = 8'($random(seed));
    dp_setup.cmp_mask = 16'hFFFF;
    dp_setup.q_out_mode = 2'b10;
    dp_setup.q_cap_alu = 2'b10;
    dp_setup.cond_sel = {4'hF, 4'h6, 4'h5, 4'h4, 4'hA, 4'h9};
    pld_rand();
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rchk(3'(i), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      host_u.wr(3'(i), v);
      rchk(3'(i), v);
    end
    host_u.wr(3'h6, 8'hAA);
    rchk(3'h6, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 20; i++)
    begin
      pld_rand();
      a = (i < 4) ? ((i % 2 == 0) ? 8'hFF : 8'h00) : 8'($random(seed));
      b = (i < 4) ? 8'h01 : 8'($random(seed));
      w = '0;
      w.op = plc_pkg::plc_alu_op_t'(3'(i % 8));
      w.shift = plc_pkg::plc_shift_t'((i < 16) ? 2'($random(seed)) : 2'h0);
      w.or_mask_en = (i < 16) && 1'($random(seed));
      w.crc_mode = (i >= 16);
      w.srca = 2'h2;
      w.srcb = 2'h1;
      w.wr_acc = 1'b1;
      w.dest_acc1 = 1'($random(seed));
      host_u.wr(plc_pkg::REG_OPD0, a);
      host_u.wr(plc_pkg::REG_OPD1, b);
      exec(3'(1 + i % 7), w, 1);
      rchk(w.dest_acc1 ? plc_pkg::REG_ACC1 : plc_pkg::REG_ACC0, ref_f(w, a, b));
    end
    $display("test alu done");
    for (int i = 0; i < 5; i++)
    begin
      v = 8'($random(seed));
      host_u.wr(plc_pkg::REG_Q0, v);
      if (i < 4)
        exp_q.push_back(v);
    end
    repeat (2) @(negedge clk);
    chk8("q0_full", 8'h01, {7'h00, cond_out[1]});
    rchk(plc_pkg::REG_Q0, 8'h00);
    w = '0;
    w.q0_act = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      exec(3'h2, w, 1);
      rchk(plc_pkg::REG_OPD0, exp_q.pop_front());
    end
    chk8("q0_empty", 8'h01, {7'h00, cond_out[0]});
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      host_u.wr(plc_pkg::REG_OPD0, v);
      w = '0;
      w.op = plc_pkg::ALU_PASS;
      w.srca = 2'h2;
      w.q1_act = 1'b1;
      exec(3'h3, w, 1);
      exp_q.push_back(v);
    end
    host_u.wr(plc_pkg::REG_Q1, 8'h5A);
    for (int i = 0; i < 5; i++)
      rchk(plc_pkg::REG_Q1, (i < 4) ? exp_q.pop_front() : 8'h00);
    $display("test queues done");
    host_u.wr(plc_pkg::REG_ACC0, 8'h00);
    dp_setup.stream_en = 1'b1;
    w = '0;
    w.op = plc_pkg::ALU_INC;
    w.srca = 2'h0;
    w.wr_acc = 1'b1;
    exec(3'h4, w, 3);
    rchk(plc_pkg::REG_ACC0, 8'h02);
    chk8("st_valid", 8'h01, {7'h00, st_valid});
    chk8("st_data", 8'h01, st_data);
    st_ready = 1'b1;
    @(negedge clk);
    chk8("st_data", 8'h02, st_data);
    @(negedge clk);
    chk8("st_valid", 8'h00, {7'h00, st_valid});
    st_ready = 1'b0;
    dp_setup.stream_en = 1'b0;
    $display("test stream done");
    give_verdict();
  end
endmodule : programmable_logic_datapath_cell_tb
